// ==== adc_clk_pkg.sv ====
// ADC clocking block package: register map, field layout, reset values, codes.
// Assumes a 16-bit register port with byte offsets as printed.
package adc_clk_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] ADDR_ADC_CLOCK_DIVIDER = 8'h44;   // Side-tone gains and rate divider.
  localparam logic [7:0] ADDR_ADC_FRAME_RATE    = 8'h46;   // Frame clock enable and phase length.
  localparam logic [7:0] ADDR_INPUT_PIN_CONNECT = 8'h48;   // Input pin connect bits.

  // ==========================================================================
  // Field positions.
  localparam int LEFT_GAIN_LSB   = 8;    // Left side-tone gain, bits 11:8.
  localparam int RIGHT_GAIN_LSB  = 4;    // Right side-tone gain, bits 7:4.
  localparam int CLK_POL_BIT     = 3;    // Stored polarity bit.
  localparam int RATE_DIV_LSB    = 0;    // Rate divider code, bits 2:0.
  localparam int FRAME_EN_BIT    = 11;   // Frame clock enable.
  localparam int PHASE_LEN_LSB   = 0;    // Phase length, bits 10:0.
  localparam int RIGHT_AUX_BIT   = 10;
  localparam int RIGHT_NEG_BIT   = 9;
  localparam int RIGHT_POS_BIT   = 8;
  localparam int LEFT_AUX_BIT    = 2;
  localparam int LEFT_NEG_BIT    = 1;
  localparam int LEFT_POS_BIT    = 0;

  // ==========================================================================
  // Reset values and writable masks.
  localparam logic [15:0] RST_ADC_CLOCK_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_ADC_FRAME_RATE    = 16'h0040;
  localparam logic [15:0] RST_INPUT_PIN_CONNECT = 16'h0303;
  localparam logic [15:0] MASK_ADC_CLOCK_DIVIDER = 16'h0fff;
  localparam logic [15:0] MASK_ADC_FRAME_RATE    = 16'h0fff;
  localparam logic [15:0] MASK_INPUT_PIN_CONNECT = 16'h0707;

  // ==========================================================================
  // Limits.
  localparam logic [10:0] MIN_PHASE_LEN  = 11'h008;  // Shortest valid phase, in bit clocks.
  localparam logic [2:0]  DIV_RESERVED   = 3'h7;     // Reserved divider code.
  localparam logic [3:0]  GAIN_MAX_CODE  = 4'hc;     // 0 dB; -36 dB at code 0, 3 dB per step.

  // Divider codes: period in half-cycles of the core audio clock.
  function automatic logic [3:0] half_period(input logic [2:0] code);
    unique case (code)
      3'h0:    half_period = 4'h2;   // Divide by 1.
      3'h1:    half_period = 4'h3;   // Divide by 1.5.
      3'h2:    half_period = 4'h4;   // Divide by 2.
      3'h3:    half_period = 4'h6;   // Divide by 3.
      3'h4:    half_period = 4'h8;   // Divide by 4.
      3'h5:    half_period = 4'hb;   // Divide by 5.5.
      3'h6:    half_period = 4'hc;   // Divide by 6.
      default: half_period = 4'h0;   // Reserved: no tick.
    endcase
  endfunction : half_period

endpackage : adc_clk_pkg

// ==== adc_rate_divider.sv ====
// Fractional rate divider: emits one-cycle tick pulses at clk / N, N in halves.
// Assumes a single clock; fractional ratios alternate floor/ceil periods.
`timescale 1ns/100ps
module adc_rate_divider (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control.
  input  wire logic [2:0] code_i,
  // Output tick.
  output logic            tick_o
);

  // ==========================================================================
  // Accumulator in half-cycles; two half-cycles elapse per clock.
  logic [3:0] acc;          // Half-cycles accumulated so far.
  logic [3:0] period;       // Divider period in half-cycles.
  logic [4:0] sum;          // Accumulator after this clock.
  logic       hit;          // Period reached this clock.

  assign period = adc_clk_pkg::half_period(code_i);
  assign sum    = {1'b0, acc} + 5'h02;
  assign hit    = (period != 4'h0) && (sum >= {1'b0, period});

  // Accumulate; on a hit keep the remainder so 1.5 and 5.5 average out.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc    <= 4'h0;
      tick_o <= 1'b0;
    end else if (period == 4'h0) begin
      acc    <= 4'h0;                                 // Reserved code: halt.
      tick_o <= 1'b0;
    end else begin
      acc    <= hit ? 4'(sum - {1'b0, period}) : sum[3:0];
      tick_o <= hit;
    end
  end

endmodule : adc_rate_divider

// ==== adc_frame_clock_gen.sv ====
// Frame clock generator: toggles the frame clock every phase_len bit ticks.
// Assumes bit_tick_i is a one-cycle enable from the rate divider.
`timescale 1ns/100ps
module adc_frame_clock_gen #(
  parameter int LEN_W = 11
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control.
  input  wire logic             enable_i,
  input  wire logic [LEN_W-1:0] phase_len_i,
  input  wire logic             bit_tick_i,
  // Output.
  output logic                  frame_clock_o
);

  // ==========================================================================
  logic [LEN_W-1:0] cnt;     // Bit clocks spent in the current phase.
  logic             valid;   // Phase length is in the legal range.
  logic             last;    // Final bit clock of this phase.

  assign valid = phase_len_i >= adc_clk_pkg::MIN_PHASE_LEN;
  assign last  = (cnt == LEN_W'(phase_len_i - 1'b1));

  // Count bit ticks and flip the phase; idle low while disabled or invalid.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt           <= '0;
      frame_clock_o <= 1'b0;
    end else if (!enable_i || !valid) begin
      cnt           <= '0;
      frame_clock_o <= 1'b0;
    end else if (bit_tick_i) begin
      if (last) begin
        cnt           <= '0;
        frame_clock_o <= ~frame_clock_o;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule : adc_frame_clock_gen

// ==== adc_clock_frame_sidetone_ctrl.sv ====
// Top of the ADC clocking block: registers, rate divider, frame clock,
// side-tone gains and input pin connect controls.
// Assumes a plain register port; read data appear the cycle after a read.
`timescale 1ns/100ps
module adc_clock_frame_sidetone_ctrl #(
  parameter int LEN_W = 11
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Clocking outputs.
  output logic             adc_rate_tick_o,
  output logic             frame_clock_o,
  output logic             adc_clock_invert_o,
  // Side-tone gain codes, and attenuation in dB below full scale, 3 dB steps.
  output logic [3:0]       left_sidetone_gain_o,
  output logic [3:0]       right_sidetone_gain_o,
  output logic [5:0]       left_sidetone_atten_db_o,
  output logic [5:0]       right_sidetone_atten_db_o,
  // Input amplifier pin switches.
  output logic             right_aux_connect_o,
  output logic             right_neg_connect_o,
  output logic             right_pos_connect_o,
  output logic             left_aux_connect_o,
  output logic             left_neg_connect_o,
  output logic             left_pos_connect_o
);

  // ==========================================================================
  // Registers.
  logic [15:0] adc_clock_divider;   // Gains, polarity, divider code.
  logic [15:0] adc_frame_rate;      // Frame enable and phase length.
  logic [15:0] input_pin_connect;   // Pin connect bits.

  // Address decode.
  wire sel_div   = (addr_i == adc_clk_pkg::ADDR_ADC_CLOCK_DIVIDER);
  wire sel_frame = (addr_i == adc_clk_pkg::ADDR_ADC_FRAME_RATE);
  wire sel_pins  = (addr_i == adc_clk_pkg::ADDR_INPUT_PIN_CONNECT);

  // Read multiplexer; unmapped addresses read zero.
  logic [15:0] next_rdata;
  assign next_rdata = sel_div   ? adc_clock_divider :
                      sel_frame ? adc_frame_rate :
                      sel_pins  ? input_pin_connect : 16'h0000;

  // Field extraction.
  wire [3:0]       left_gain  = adc_clock_divider[adc_clk_pkg::LEFT_GAIN_LSB +: 4];
  wire [3:0]       right_gain = adc_clock_divider[adc_clk_pkg::RIGHT_GAIN_LSB +: 4];
  wire [2:0]       div_code   = adc_clock_divider[adc_clk_pkg::RATE_DIV_LSB +: 3];
  wire             frame_en   = adc_frame_rate[adc_clk_pkg::FRAME_EN_BIT];
  wire [LEN_W-1:0] phase_len  = adc_frame_rate[adc_clk_pkg::PHASE_LEN_LSB +: LEN_W];

  // ==========================================================================
  // Gain code to attenuation: codes above 0 dB clamp to 0 dB.
  function automatic logic [5:0] atten_db(input logic [3:0] code);
    logic [3:0] c;
    c = (code > adc_clk_pkg::GAIN_MAX_CODE) ? adc_clk_pkg::GAIN_MAX_CODE : code;
    atten_db = 6'(({2'h0, adc_clk_pkg::GAIN_MAX_CODE} - {2'h0, c}) * 6'h03);
  endfunction : atten_db

  // ==========================================================================
  // Register writes; reserved bits are masked and read as zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_clock_divider <= adc_clk_pkg::RST_ADC_CLOCK_DIVIDER;
      adc_frame_rate    <= adc_clk_pkg::RST_ADC_FRAME_RATE;
      input_pin_connect <= adc_clk_pkg::RST_INPUT_PIN_CONNECT;
    end else if (wr_i) begin
      if (sel_div)   adc_clock_divider <= wdata_i & adc_clk_pkg::MASK_ADC_CLOCK_DIVIDER;
      if (sel_frame) adc_frame_rate    <= wdata_i & adc_clk_pkg::MASK_ADC_FRAME_RATE;
      if (sel_pins)  input_pin_connect <= wdata_i & adc_clk_pkg::MASK_INPUT_PIN_CONNECT;
    end
  end

  // Read data for exactly one cycle after the read strobe.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? next_rdata : 16'h0000;
    end
  end

  // ==========================================================================
  // Rate divider and frame clock.
  logic bit_tick;   // One-cycle enable at the divided rate.

  adc_rate_divider u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .code_i (div_code),
    .tick_o (bit_tick)
  );

  logic frame_clk;  // Frame clock from the generator.

  adc_frame_clock_gen #(.LEN_W(LEN_W)) u_frame (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .enable_i      (frame_en),
    .phase_len_i   (phase_len),
    .bit_tick_i    (bit_tick),
    .frame_clock_o (frame_clk)
  );

  // ==========================================================================
  // Output flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_rate_tick_o           <= 1'b0;
      frame_clock_o             <= 1'b0;
      adc_clock_invert_o        <= 1'b0;
      left_sidetone_gain_o      <= 4'h0;
      right_sidetone_gain_o     <= 4'h0;
      left_sidetone_atten_db_o  <= 6'h24;
      right_sidetone_atten_db_o <= 6'h24;
      right_aux_connect_o       <= 1'b0;
      right_neg_connect_o       <= 1'b1;
      right_pos_connect_o       <= 1'b1;
      left_aux_connect_o        <= 1'b0;
      left_neg_connect_o        <= 1'b1;
      left_pos_connect_o        <= 1'b1;
    end else begin
      adc_rate_tick_o           <= bit_tick;
      frame_clock_o             <= frame_clk;
      adc_clock_invert_o        <= adc_clock_divider[adc_clk_pkg::CLK_POL_BIT];
      left_sidetone_gain_o      <= left_gain;
      right_sidetone_gain_o     <= right_gain;
      left_sidetone_atten_db_o  <= atten_db(left_gain);
      right_sidetone_atten_db_o <= atten_db(right_gain);
      right_aux_connect_o       <= input_pin_connect[adc_clk_pkg::RIGHT_AUX_BIT];
      right_neg_connect_o       <= input_pin_connect[adc_clk_pkg::RIGHT_NEG_BIT];
      right_pos_connect_o       <= input_pin_connect[adc_clk_pkg::RIGHT_POS_BIT];
      left_aux_connect_o        <= input_pin_connect[adc_clk_pkg::LEFT_AUX_BIT];
      left_neg_connect_o        <= input_pin_connect[adc_clk_pkg::LEFT_NEG_BIT];
      left_pos_connect_o        <= input_pin_connect[adc_clk_pkg::LEFT_POS_BIT];
    end
  end

endmodule : adc_clock_frame_sidetone_ctrl

// ==== adc_ctrl_sva.sv ====
// Checker for the ADC clocking block; sees only the top module's ports.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/100ps
module adc_ctrl_sva (
  // Clock, reset and register port.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  // Watched outputs.
  input wire logic        adc_rate_tick_o,
  input wire logic        frame_clock_o,
  input wire logic [3:0]  left_sidetone_gain_o,
  input wire logic [3:0]  right_sidetone_gain_o,
  input wire logic [5:0]  left_sidetone_atten_db_o,
  input wire logic [5:0]  right_sidetone_atten_db_o,
  input wire logic        right_aux_connect_o,
  input wire logic        right_neg_connect_o,
  input wire logic        right_pos_connect_o,
  input wire logic        left_aux_connect_o,
  input wire logic        left_pos_connect_o
);
  // ==========================================================================
  // Shadow registers and a count of quiet cycles since the last write.
  logic [15:0] div_q;   // Shadow of the divider register.
  logic [15:0] frm_q;   // Shadow of the frame rate register.
  logic [15:0] pin_q;   // Shadow of the pin connect register.
  logic [3:0]  quiet;   // Saturating count of cycles without a write.
  logic [3:0]  cl;      // Left gain clamped to 0 dB.
  logic [3:0]  cr;      // Right gain clamped to 0 dB.
  assign cl = (left_sidetone_gain_o > 4'hc) ? 4'hc : left_sidetone_gain_o;
  assign cr = (right_sidetone_gain_o > 4'hc) ? 4'hc : right_sidetone_gain_o;

  // Tracks what software wrote, so outputs can be judged against it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= adc_clk_pkg::RST_ADC_CLOCK_DIVIDER;
      frm_q <= adc_clk_pkg::RST_ADC_FRAME_RATE;
      pin_q <= adc_clk_pkg::RST_INPUT_PIN_CONNECT;
      quiet <= 4'h0;
    end else begin
      if (wr_i && addr_i == adc_clk_pkg::ADDR_ADC_CLOCK_DIVIDER) div_q <= wdata_i;
      if (wr_i && addr_i == adc_clk_pkg::ADDR_ADC_FRAME_RATE) frm_q <= wdata_i;
      if (wr_i && addr_i == adc_clk_pkg::ADDR_INPUT_PIN_CONNECT) pin_q <= wdata_i;
      quiet <= wr_i ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Assertions.
  a_left_gain_steps: assert property (
    left_sidetone_atten_db_o == (6'hc - {2'h0, cl}) * 6'h3) else $error("left side-tone attenuation wrong");
  a_right_gain_steps: assert property (
    right_sidetone_atten_db_o == (6'hc - {2'h0, cr}) * 6'h3) else $error("right side-tone attenuation wrong");
  a_div4_tick_spacing: assert property (
    quiet > 4'h8 && div_q[2:0] == 3'h4 && adc_rate_tick_o |=> !adc_rate_tick_o [*3] ##1 adc_rate_tick_o)
    else $error("divide by 4 tick spacing wrong");
  a_reserved_no_tick: assert property (
    quiet > 4'h6 && div_q[2:0] == 3'h7 |-> !adc_rate_tick_o) else $error("tick seen on reserved code");
  a_frame_off_low: assert property (
    quiet > 4'h4 && !frm_q[11] |-> !frame_clock_o) else $error("frame clock runs while disabled");
  a_short_phase_low: assert property (
    quiet > 4'h4 && frm_q[10:0] < 11'h8 |-> !frame_clock_o) else $error("frame clock runs on invalid length");
  a_right_aux_pin: assert property (
    quiet > 4'h2 |-> right_aux_connect_o == pin_q[10]) else $error("right aux connect wrong");
  a_right_neg_pin: assert property (
    quiet > 4'h2 |-> right_neg_connect_o == pin_q[9]) else $error("right negative connect wrong");
  a_right_pos_pin: assert property (
    quiet > 4'h2 |-> right_pos_connect_o == pin_q[8]) else $error("right positive connect wrong");
  a_left_aux_pin: assert property (
    quiet > 4'h2 |-> left_aux_connect_o == pin_q[2]) else $error("left aux connect wrong");
  a_left_pos_pin: assert property (
    quiet > 4'h2 |-> left_pos_connect_o == pin_q[0]) else $error("left positive connect wrong");

  // Main scenarios reached.
  c_frame_toggle: cover property ($rose(frame_clock_o));
  c_tick_frac: cover property (adc_rate_tick_o && div_q[2:0] == 3'h5);
  c_aux_on: cover property (quiet > 4'h2 && right_aux_connect_o);
endmodule : adc_ctrl_sva

bind adc_clock_frame_sidetone_ctrl adc_ctrl_sva adc_ctrl_sva_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .adc_rate_tick_o(adc_rate_tick_o), .frame_clock_o(frame_clock_o),
  .left_sidetone_gain_o(left_sidetone_gain_o), .right_sidetone_gain_o(right_sidetone_gain_o),
  .left_sidetone_atten_db_o(left_sidetone_atten_db_o), .right_sidetone_atten_db_o(right_sidetone_atten_db_o),
  .right_aux_connect_o(right_aux_connect_o), .right_neg_connect_o(right_neg_connect_o),
  .right_pos_connect_o(right_pos_connect_o), .left_aux_connect_o(left_aux_connect_o),
  .left_pos_connect_o(left_pos_connect_o));

// ==== adc_clock_frame_sidetone_ctrl_tb_top.sv ====
// Self-checking testbench for the ADC clocking block, driven over its register port.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/100ps
module adc_clock_frame_sidetone_ctrl_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic        tick, frame, inv, r_aux, r_neg, r_pos, l_aux, l_neg, l_pos;
  logic [3:0]  l_gain, r_gain;
  logic [5:0]  l_att, r_att;
  int          n_mismatch = 0, n_tests = 0, c;
  int          codes[8] = '{0, 1, 2, 3, 5, 6, 7, 4};       // Divide by 4 last.
  int          ticks[8] = '{132, 88, 66, 44, 24, 22, 0, 33}; // Ticks per 132 clocks.
  int          pins[6] = '{10, 9, 8, 2, 1, 0};              // Connect bit positions.

  adc_clock_frame_sidetone_ctrl adc_clock_frame_sidetone_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_rate_tick_o(tick), .frame_clock_o(frame),
    .adc_clock_invert_o(inv), .left_sidetone_gain_o(l_gain), .right_sidetone_gain_o(r_gain),
    .left_sidetone_atten_db_o(l_att), .right_sidetone_atten_db_o(r_att), .right_aux_connect_o(r_aux),
    .right_neg_connect_o(r_neg), .right_pos_connect_o(r_pos), .left_aux_connect_o(l_aux),
    .left_neg_connect_o(l_neg), .left_pos_connect_o(l_pos));

  // 40 MHz clock.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Counts one comparison and reports it if it fails.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write, then one more edge for the outputs to follow.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : wr

  // One-cycle read; data are looked at in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd

  // Clocks until the frame clock changes level, with a bound.
  task automatic wait_edge(output int cyc);
    logic prev;
    prev = frame;
    cyc = 0;
    do begin
      @(posedge clk_i);
      #1;
      cyc++;
    end while (frame === prev && cyc < 3000);
    if (cyc >= 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : wait_edge

  // Counts frame clock high cycles or rate ticks over a window.
  task automatic count(input int n, input logic pick, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      hits += pick ? int'(tick === 1'b1) : int'(frame === 1'b1);
    end
  endtask : count

  // Attenuation in dB for a gain code, clamped at 0 dB.
  function automatic logic [5:0] att(input logic [3:0] g);
    att = 6'((12 - ((g > 4'hc) ? 12 : int'(g))) * 3);
  endfunction : att

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({10'h0, r_aux, r_neg, r_pos, l_aux, l_neg, l_pos}, 16'h001b);
    rd(8'h44, 16'h0000);
    rd(8'h46, 16'h0040);
    rd(8'h48, 16'h0303);
    rd(8'h4a, 16'h0000);
    @(posedge clk_i);
    #1;
    chk(rdata_o, 16'h0000);
    for (int g = 0; g < 16; g++) begin
      wr(8'h44, {4'h0, 4'(g), ~4'(g), 4'(g) & 4'h8});
      chk({15'h0, inv}, 16'((g >> 3) & 1));
      chk({8'h0, l_gain, r_gain}, {8'h0, 4'(g), ~4'(g)});
      chk({4'h0, l_att, r_att}, {4'h0, att(4'(g)), att(~4'(g))});
    end
    rd(8'h44, 16'h0f08);
    wr(8'h44, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(8'h48, 16'h0001 << pins[i]);
      chk({10'h0, r_aux, r_neg, r_pos, l_aux, l_neg, l_pos}, 16'h0020 >> i);
    end
    wr(8'h4a, 16'hffff);
    rd(8'h48, 16'h0001);
    wr(8'h48, 16'hffff);
    rd(8'h48, 16'h0707);
    foreach (codes[k]) begin
      if (k == 0) begin
        foreach (ticks[p]) begin
          if (p < 2) begin
            wr(8'h46, (p == 0) ? 16'h0808 : 16'h0fff);
            wait_edge(c);
            wait_edge(c);
            chk(16'(c), (p == 0) ? 16'h0008 : 16'h07ff);
          end
        end
        wr(8'h46, 16'h0807);
        count(64, 1'b0, c);
        chk(16'(c), 16'h0000);
        wr(8'h46, 16'h0008);
        count(64, 1'b0, c);
        chk(16'(c), 16'h0000);
      end
      wr(8'h44, 16'(codes[k]));
      repeat (6) @(posedge clk_i);
      count(132, 1'b1, c);
      chk(16'(c), 16'(ticks[k]));
    end
    count(40, 1'b1, c);
    tally_and_finish();
  end
endmodule : adc_clock_frame_sidetone_ctrl_tb_top
